// >>> hdl/sai_sample_mem.sv
// Eight-word store of the latest captured samples, registered read
`timescale 1ns/1ns
`default_nettype none
module sai_sample_mem
  import sai_pkg::*;
(
  input wire logic aclk,
  input wire logic wr_en,
  input wire sai_wr_t wr,
  input wire logic rd_en,
  input wire logic [2:0] rd_addr,
  output logic [`SAI_WORD_BITS-1:0] rd_data
);

  logic [`SAI_WORD_BITS-1:0] mem_q [0:`SAI_CHANNELS-1];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_q[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : sai_sample_mem
`default_nettype wire

// >>> hdl/sai_serial_in.sv
// Serial audio input port: framing on the bit clock, registers over AXI4-Lite
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module sai_serial_in
  import sai_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_bclk,
  input wire logic frame_clock,
  input wire logic [`SAI_LANES-1:0] serial_data_inputs
);

  // ---------------- Register side (aclk) ----------------
  sai_ctrl_t ctrl_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q, w_held_q;
  logic [13:0] aw_idx, ar_idx;
  logic wr_fire, wr_ctrl_hit;
  sai_rd_state_t rd_state_q;
  sai_rsel_t rsel_q, ar_sel;
  logic [15:0] words_q;
  logic [`SAI_WORD_BITS-1:0] mem_rdata;

  assign aw_idx = awaddr_q[15:2];
  assign ar_idx = s_axi_araddr[15:2];
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ctrl_hit = aw_idx == `SAI_CTRL_IDX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_q <= 1'b0;
      awaddr_q <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q;
    end
  end

  // Only the control register takes writes; samples and status are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ctrl_hit ? `SAI_RESP_OKAY : `SAI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SAI_CTRL_RESET;
    end else if (wr_fire && wr_ctrl_hit && wstrb_q[0]) begin
      ctrl_q <= wdata_q[7:0] & `SAI_CTRL_WMASK;
    end
  end

  always_comb begin
    if (ar_idx == `SAI_CTRL_IDX) begin
      ar_sel = RSEL_CTRL;
    end else if (ar_idx == `SAI_STATUS_IDX) begin
      ar_sel = RSEL_STATUS;
    end else if (ar_idx[13:3] == 11'(`SAI_SAMPLE_IDX >> 3)) begin
      ar_sel = RSEL_SAMPLE;
    end else begin
      ar_sel = RSEL_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      rsel_q <= RSEL_NONE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SAI_RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            rsel_q <= ar_sel;
            rd_state_q <= RD_DATA;
          end
        end
        RD_DATA: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp <= (rsel_q == RSEL_NONE) ? `SAI_RESP_SLVERR : `SAI_RESP_OKAY;
          case (rsel_q)
            RSEL_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
            RSEL_SAMPLE: s_axi_rdata <= {8'h00, mem_rdata};
            RSEL_STATUS: s_axi_rdata <= {16'h0000, words_q};
            default: s_axi_rdata <= 32'h00000000;
          endcase
          rd_state_q <= RD_RESP;
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_q <= RD_IDLE;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  // ---------------- Link side (link_bclk) ----------------
  logic lrst_s1_q, lrst_s2_q, link_rst_n;
  sai_ctrl_t lctrl_s1_q, lctrl;
  logic [`SAI_LANES-1:0] rise_sd_q, fall_sd_q, sd_q;
  logic rise_fc_q, fall_fc_q, fc_q, fc_prev_q;
  logic is_tdm, fc_rise, fc_fall, start, cap, last;
  logic [7:0] delay, cnt_q, cur_idx, pos;
  logic chan_q, hold_tdm_q, tog_q;
  logic [2:0] hold_sel_q;
  logic [`SAI_WORD_BITS-1:0] shreg_q [0:`SAI_LANES-1];
  logic [`SAI_WORD_BITS-1:0] hold_q [0:`SAI_LANES-1];

  always_ff @(posedge link_bclk) begin
    lrst_s1_q <= aresetn;
    lrst_s2_q <= lrst_s1_q;
  end
  assign link_rst_n = lrst_s2_q;

  // Control is quasi-static; software changes all five bits in one write
  always_ff @(posedge link_bclk) begin
    lctrl_s1_q <= ctrl_q;
    lctrl <= lctrl_s1_q;
  end

  // Capture on both edges, then keep the one opposite the change edge
  always_ff @(posedge link_bclk) begin
    rise_sd_q <= serial_data_inputs;
    rise_fc_q <= frame_clock;
  end
  always_ff @(negedge link_bclk) begin
    fall_sd_q <= serial_data_inputs;
    fall_fc_q <= frame_clock;
  end
  always_ff @(posedge link_bclk) begin
    sd_q <= lctrl.bit_clock_polarity ? fall_sd_q : rise_sd_q;
    fc_q <= lctrl.bit_clock_polarity ? fall_fc_q : rise_fc_q;
    fc_prev_q <= fc_q;
  end

  assign is_tdm = lctrl.format_select == `SAI_FMT_TDM;
  assign delay = (is_tdm || lctrl.format_select == `SAI_FMT_I2S) ? 8'h01 : 8'h00;
  assign fc_rise = fc_q && !fc_prev_q;
  assign fc_fall = !fc_q && fc_prev_q;
  // Only the leading edge restarts a TDM frame, so a pulse clock works too
  assign start = is_tdm ? (lctrl.frame_clock_polarity ? fc_rise : fc_fall)
                        : (fc_rise || fc_fall);
  assign cur_idx = start ? 8'h00 : ((cnt_q == `SAI_IDX_IDLE) ? `SAI_IDX_IDLE : 8'(cnt_q + 8'h01));
  assign pos = is_tdm ? {3'h0, cur_idx[4:0]} : cur_idx;
  assign cap = (pos >= delay) && (pos < 8'(delay + `SAI_WORD_SPAN));
  assign last = pos == 8'(delay + `SAI_WORD_SPAN - 8'h01);

  // Idle count until the first frame edge, so no half word is taken
  always_ff @(posedge link_bclk) begin
    if (!link_rst_n) begin
      cnt_q <= `SAI_IDX_IDLE;
    end else begin
      cnt_q <= cur_idx;
    end
  end

  always_ff @(posedge link_bclk) begin
    if (!link_rst_n) begin
      chan_q <= 1'b0;
    end else if (start) begin
      chan_q <= fc_q ^ lctrl.frame_clock_polarity;
    end
  end

  for (genvar g = 0; g < `SAI_LANES; g++) begin : g_lane
    always_ff @(posedge link_bclk) begin
      if (cap) begin
        shreg_q[g] <= {shreg_q[g][`SAI_WORD_BITS-2:0], sd_q[g]};
      end
      if (last) begin
        hold_q[g] <= {shreg_q[g][`SAI_WORD_BITS-2:0], sd_q[g]};
      end
    end
  end

  always_ff @(posedge link_bclk) begin
    if (!link_rst_n) begin
      tog_q <= 1'b0;
      hold_tdm_q <= 1'b0;
      hold_sel_q <= 3'h0;
    end else if (last) begin
      tog_q <= !tog_q;
      hold_tdm_q <= is_tdm;
      hold_sel_q <= is_tdm ? cur_idx[7:5] : {2'h0, chan_q};
    end
  end

  // ---------------- Crossing and sample store (aclk) ----------------
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  sai_cp_state_t cp_state_q;
  logic [1:0] lane_q;
  logic rd_en;
  sai_wr_t mem_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Hold words stay put for a whole word time after the toggle
  assign mem_wr.addr = hold_tdm_q ? hold_sel_q : {lane_q, hold_sel_q[0]};
  assign mem_wr.data = hold_q[lane_q];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_state_q <= CP_IDLE;
      lane_q <= 2'h0;
      words_q <= 16'h0000;
    end else begin
      case (cp_state_q)
        CP_IDLE: begin
          lane_q <= 2'h0;
          if (tog_s2_q != tog_s3_q) begin
            cp_state_q <= CP_RUN;
          end
        end
        CP_RUN: begin
          words_q <= words_q + 16'h0001;
          lane_q <= lane_q + 2'h1;
          if (hold_tdm_q || lane_q == 2'h3) begin
            cp_state_q <= CP_IDLE;
          end
        end
        default: cp_state_q <= CP_IDLE;
      endcase
    end
  end

  assign rd_en = rd_state_q == RD_IDLE && s_axi_arvalid && s_axi_arready;

  sai_sample_mem u_mem (
    .aclk(aclk),
    .wr_en(cp_state_q == CP_RUN),
    .wr(mem_wr),
    .rd_en(rd_en),
    .rd_addr(ar_idx[2:0]),
    .rd_data(mem_rdata)
  );

  // ---------------- Assertions ----------------
  sequence s_tdm_start;
    is_tdm && start;
  endsequence

  property p_ctrl_write;
    @(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_ctrl_hit && wstrb_q[0]) |=> (ctrl_q[7:5] == 3'h0) && (ctrl_q[4:0] == $past(wdata_q[4:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_read_latency;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer not on time");

  property p_left_low;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (!is_tdm && start && !lctrl.frame_clock_polarity) |=> chan_q == $past(fc_q);
  endproperty
  a_left_low: assert property (p_left_low) else $error("channel wrong for polarity 0");

  property p_left_high;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (!is_tdm && start && lctrl.frame_clock_polarity) |=> chan_q == !$past(fc_q);
  endproperty
  a_left_high: assert property (p_left_high) else $error("channel wrong for polarity 1");

  property p_tdm_fall;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (is_tdm && !lctrl.frame_clock_polarity && fc_fall && $stable(lctrl)) |=> cnt_q == 8'h00;
  endproperty
  a_tdm_fall: assert property (p_tdm_fall) else $error("TDM frame not started on falling edge");

  property p_tdm_rise;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (is_tdm && lctrl.frame_clock_polarity && fc_rise && $stable(lctrl)) |=> cnt_q == 8'h00;
  endproperty
  a_tdm_rise: assert property (p_tdm_rise) else $error("TDM frame not started on rising edge");

  property p_pulse_trailing;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (is_tdm && !start && cnt_q != `SAI_IDX_IDLE) |=> cnt_q == 8'($past(cnt_q) + 8'h01);
  endproperty
  a_pulse_trailing: assert property (p_pulse_trailing) else $error("trailing pulse edge restarted frame");

  property p_msb_delay;
    @(posedge link_bclk) disable iff (!link_rst_n)
      s_tdm_start |-> !cap ##1 (cap || start);
  endproperty
  a_msb_delay: assert property (p_msb_delay) else $error("TDM MSB not one bit late");

  property p_slot_half;
    @(posedge link_bclk) disable iff (!link_rst_n)
      (is_tdm && last && cur_idx[7:5] < `SAI_TDM_HALF) |=> !hold_sel_q[2] && hold_tdm_q;
  endproperty
  a_slot_half: assert property (p_slot_half) else $error("first-half slot mapped wrong");

endmodule : sai_serial_in
`default_nettype wire

// >>> include/sai_defines.svh
// Register map, field positions and framing constants of the serial audio input
`ifndef SAI_DEFINES_SVH
`define SAI_DEFINES_SVH

`define SAI_CTRL_IDX 14'h081F
`define SAI_SAMPLE_IDX 14'h0820
`define SAI_STATUS_IDX 14'h0828
`define SAI_CTRL_RESET 8'h00
`define SAI_CTRL_WMASK 8'h1F
`define SAI_FMT_I2S 3'h0
`define SAI_FMT_LJ 3'h1
`define SAI_FMT_TDM 3'h2
`define SAI_LANES 4
`define SAI_CHANNELS 8
`define SAI_WORD_BITS 24
`define SAI_WORD_SPAN 8'h18
`define SAI_TDM_HALF 3'h4
`define SAI_IDX_IDLE 8'hFF
`define SAI_RESP_OKAY 2'h0
`define SAI_RESP_SLVERR 2'h2

`endif

// >>> include/sai_pkg.sv
// Types shared by the serial audio input and its sample store
`include "sai_defines.svh"
package sai_pkg;

  typedef struct packed {
    logic [2:0] zero;
    logic frame_clock_polarity;
    logic bit_clock_polarity;
    logic [2:0] format_select;
  } sai_ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [`SAI_WORD_BITS-1:0] data;
  } sai_wr_t;

  typedef enum logic [1:0] {RSEL_CTRL, RSEL_SAMPLE, RSEL_STATUS, RSEL_NONE} sai_rsel_t;
  typedef enum logic [1:0] {RD_IDLE, RD_DATA, RD_RESP} sai_rd_state_t;
  typedef enum logic {CP_IDLE, CP_RUN} sai_cp_state_t;

endpackage : sai_pkg

// >>> tb/sai_serial_in_tb_top.sv
// Self-checking bench for the serial audio input: registers and framing
`timescale 1ns/1ns
`default_nettype none
`include "sai_defines.svh"
module sai_serial_in_tb_top;
  import sai_pkg::*;
  localparam int LIMIT = 30000;
  localparam logic [15:0] CTRL_A = {`SAI_CTRL_IDX, 2'b00};
  localparam logic [15:0] STAT_A = {`SAI_STATUS_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic link_bclk;
  logic frame_clock;
  logic [3:0] serial_data_inputs;
  logic bit_clock_polarity = 1'b0;
  logic frame_clock_polarity = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2 aclk = ~aclk;

  sai_serial_in sai_serial_in_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .link_bclk, .frame_clock, .serial_data_inputs);

  sai_source_model sai_source_model_inst (.link_bclk, .frame_clock, .serial_data_inputs, .bit_clock_polarity,
    .frame_clock_polarity);

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t ns got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(CTRL_A, d, r);
    chk(d, 32'h00000000);
    wr(CTRL_A, 8'hFF, r);
    rd(CTRL_A, d, r);
    chk(d, 32'h0000001F);
    wr(16'h3000, 8'h55, r);
    chk({30'h0, r}, 32'h00000002);
    rd(16'h3000, d, r);
    chk({d[29:0], r}, 32'h00000002);
    rd(CTRL_A, d, r);
    chk(d, 32'h0000001F);
  endtask : t_regs

  // All five format bits go in one write; the link needs clocks to see them
  task automatic t_frame(input logic p, input logic q, input logic [2:0] f, input int c);
    logic [31:0] d;
    logic [31:0] s0;
    logic [1:0] r;
    logic tdm;
    tdm = (f == `SAI_FMT_TDM);
    for (int i = 0; i < 8; i++) sai_source_model_inst.words[i] = 24'h9A5C31 ^ (24'(c) << 12) ^ (24'(i) * 24'h010203);
    bit_clock_polarity = q;
    frame_clock_polarity = p;
    wr(CTRL_A, {3'h0, p, q, f}, r);
    chk({30'h0, r}, 32'h00000000);
    sai_source_model_inst.idle(6);
    rd(STAT_A, s0, r);
    sai_source_model_inst.send(tdm, (f == `SAI_FMT_I2S || tdm) ? 1 : 0);
    sai_source_model_inst.idle(4);
    for (int i = 0; i < 8; i++) begin
      rd({`SAI_SAMPLE_IDX + 14'(i), 2'b00}, d, r);
      chk(d, {8'h00, sai_source_model_inst.words[i]});
    end
    rd(STAT_A, d, r);
    chk({16'h0000, d[15:0] - s0[15:0]}, 32'h00000008);
  endtask : t_frame

  initial begin
    fork
      sai_source_model_inst.idle(3);
    join_none
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frame(1'b0, 1'b0, `SAI_FMT_I2S, 1);
    t_frame(1'b1, 1'b1, `SAI_FMT_LJ, 2);
    t_frame(1'b0, 1'b1, `SAI_FMT_I2S, 3);
    t_frame(1'b1, 1'b0, `SAI_FMT_LJ, 4);
    t_frame(1'b0, 1'b0, `SAI_FMT_TDM, 5);
    t_frame(1'b1, 1'b1, `SAI_FMT_TDM, 6);
    wrap_up();
  end
endmodule : sai_serial_in_tb_top
`default_nettype wire

// >>> tb/sai_source_model.sv
// Behavioural audio source: bit clock, frame clock and four serial data lanes
`timescale 1ns/1ns
`default_nettype none
module sai_source_model (
  output logic link_bclk,
  output logic frame_clock,
  output logic [3:0] serial_data_inputs,
  input wire logic bit_clock_polarity,
  input wire logic frame_clock_polarity
);
  logic [23:0] words [0:7];

  initial begin
    link_bclk = 1'b1;
    frame_clock = 1'b1;
    serial_data_inputs = 4'h0;
  end

  // Change edge first, then capture edge; clock parks at the capture level
  task automatic tick(input logic fc, input logic [3:0] d);
    link_bclk = bit_clock_polarity;
    frame_clock = fc;
    serial_data_inputs = d;
    #6;
    link_bclk = ~bit_clock_polarity;
    #6;
  endtask : tick

  // Lanes toggle while idle so a stale bit never looks valid
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) tick(~frame_clock_polarity, ~serial_data_inputs);
  endtask : idle

  task automatic send(input logic tdm, input int dly);
    logic [3:0] d;
    logic fc;
    logic [23:0] w;
    idle(1);
    for (int s = 0; s < (tdm ? 8 : 2); s++) begin
      for (int b = 0; b < 32; b++) begin
        fc = tdm ? ((s == 0 && b == 0) ? frame_clock_polarity : ~frame_clock_polarity)
                 : (s[0] ^ frame_clock_polarity);
        for (int l = 0; l < 4; l++) begin
          w = tdm ? words[s] : words[l * 2 + s];
          d[l] = (b >= dly && b < dly + 24) ? w[23 - (b - dly)] : b[0];
        end
        tick(fc, d);
      end
    end
    serial_data_inputs = ~serial_data_inputs;
  endtask : send
endmodule : sai_source_model
`default_nettype wire
